/* File: rtl/pse_event_pkg.sv */
// constants for the start/limit and supply event flag block
// assumes a command decoder that hands over one-byte register reads
//
// Notes on behaviour
// - limit flag sets once a port stays in current limit past the limit time
// - set a port's turn-on flag on a start-time fault during turn-on
// - also set it on class or detect error during a standard power enable
// - supply read at code 0Ah returns the flags and leaves them alone
// - supply read at code 0Bh returns the same data then clears the supply flags
// - clearing read releases the interrupt line if supply flags caused it
// - any set supply flag feeds the interrupt summary and interrupt line
// - the four low supply bits are reserved and carry no event
// - thermal shutdown sets bit 7, turns all ports off, forces off mode
// - logic keeps running; ports may re-enable once below low temperature
// - core supply lockout sets bit 6; the flag is 1 after power-on reset
// - core supply dropping below the warning threshold sets bit 5
// - port power rail undervoltage sets bit 4
// - external reset pin leaves the core lockout and rail flags untouched
// - rail undervoltage shuts all ports off only when the shutdown mask is 1
// - rail lockout or core lockout requests a full power-on reset
// - undervoltage turn-off clears the port's fault, status and enable bits
// - such a turn-off sets the port's power-good and enable change flags
// - such a turn-off updates the port's enable and power-good status bits
// - turning a port off clears its start and limit flags
// - core lockout flag re-sets after a clear while rail undervoltage persists
// - with the mask at 0 rail undervoltage keeps ports powered
package pse_event_pkg;

  localparam int PORTS = 4;

  // command codes of the two registers
  localparam logic [7:0] CMD_START_LIMIT_PEEK = 8'h08;
  localparam logic [7:0] CMD_START_LIMIT_CLEAR = 8'h09;
  localparam logic [7:0] CMD_SUPPLY_PEEK = 8'h0A;
  localparam logic [7:0] CMD_SUPPLY_CLEAR = 8'h0B;

  // supply event bit positions
  localparam int THERMAL_BIT = 7;
  localparam int CORE_LOCKOUT_BIT = 6;
  localparam int CORE_WARNING_BIT = 5;
  localparam int RAIL_UV_BIT = 4;

  // start/limit fields: limit flags high nibble, turn-on flags low nibble
  localparam int LIMIT_LSB = 4;
  localparam int TURN_ON_LSB = 0;

  // values after power-on reset
  localparam logic [3:0] SUPPLY_RESET = 4'h4;
  localparam logic [7:0] START_LIMIT_RESET = 8'h00;
  localparam logic [3:0] RESERVED_READ = 4'h0;

  // synchroniser index of each asynchronous pin, and their idle levels
  localparam int SYNC_W = 7;
  localparam int PIN_OVER_TEMP = 0;
  localparam int PIN_TEMP_LOW = 1;
  localparam int PIN_CORE_UVLO = 2;
  localparam int PIN_CORE_WARN = 3;
  localparam int PIN_RAIL_UV = 4;
  localparam int PIN_RAIL_UVLO = 5;
  localparam int PIN_EXT_RESET_N = 6;
  localparam logic [6:0] SYNC_RESET = 7'h40;

  // limit fault time; no figure is fixed, so a plain default in cycles
  localparam int LIMIT_FAULT_CYCLES_DEF = 1000000;
  localparam int LIMIT_CNT_W = 24;

  typedef enum logic [0:0] {
    TH_NORMAL = 1'b0,
    TH_HOT = 1'b1
  } thermal_t;

endpackage

/* File: rtl/limit_fault_timer.sv */
// per-port timers that measure how long a port sits in current limit
// assumes limit_active comes from port logic on mclk
`timescale 1ns/100ps
module limit_fault_timer #(
  parameter int LIMIT_FAULT_CYCLES = pse_event_pkg::LIMIT_FAULT_CYCLES_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // per-port limit state
  input wire logic [pse_event_pkg::PORTS-1:0] limit_active,
  output logic [pse_event_pkg::PORTS-1:0] limit_expired
);

  localparam logic [pse_event_pkg::LIMIT_CNT_W-1:0] LAST =
    pse_event_pkg::LIMIT_CNT_W'(LIMIT_FAULT_CYCLES);

  genvar i;
  generate
    for (i = 0; i < pse_event_pkg::PORTS; i++) begin : g_port
      logic [pse_event_pkg::LIMIT_CNT_W-1:0] cnt_r;
      // counter parks at the limit so the expiry pulses only once per stay
      always_ff @(posedge mclk) begin
        if (rst || !limit_active[i]) begin
          cnt_r <= '0;
        end else if (cnt_r != LAST) begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
      assign limit_expired[i] = limit_active[i] &&
        (cnt_r == LAST - 1'b1);
    end
  endgenerate

endmodule

/* File: rtl/pse_start_limit_supply_events.sv */
// start/limit and supply event flags of a four-port power sourcing block
// assumes: cmd_valid/cmd_code from the serial command decoder on mclk;
// supply and thermal comparators arrive asynchronously on pins
`timescale 1ns/100ps
module pse_start_limit_supply_events #(
  parameter int LIMIT_FAULT_CYCLES = pse_event_pkg::LIMIT_FAULT_CYCLES_DEF
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic rst,
  // register reads from the command decoder
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic rd_valid_r,
  output logic [7:0] rd_data_r,
  // per-port events from port logic
  input wire logic [pse_event_pkg::PORTS-1:0] limit_active,
  input wire logic [pse_event_pkg::PORTS-1:0] start_timeout,
  input wire logic [pse_event_pkg::PORTS-1:0] class_det_error,
  input wire logic [pse_event_pkg::PORTS-1:0] std_enable_turn_on,
  input wire logic [pse_event_pkg::PORTS-1:0] port_turned_off,
  input wire logic [pse_event_pkg::PORTS-1:0] port_powered,
  // asynchronous supply and thermal pins
  input wire logic over_temp_pin,
  input wire logic temp_below_low_pin,
  input wire logic core_uvlo_pin,
  input wire logic core_warn_pin,
  input wire logic rail_uv_pin,
  input wire logic rail_uvlo_pin,
  input wire logic ext_reset_n_pin,
  // configuration
  input wire logic supply_event_shutdown_mask,
  // port control towards the rest of the device
  output logic all_ports_off_r,
  output logic force_off_mode_r,
  output logic [pse_event_pkg::PORTS-1:0] uv_port_clear_r,
  output logic [pse_event_pkg::PORTS-1:0] uv_change_set_r,
  output logic [pse_event_pkg::PORTS-1:0] uv_status_update_r,
  output logic por_request_r,
  // interrupt summary
  output logic supply_summary,
  output logic start_limit_summary,
  output logic int_n
);

  // two-stage synchroniser for every pin
  logic [pse_event_pkg::SYNC_W-1:0] pins;
  logic [pse_event_pkg::SYNC_W-1:0] meta_r;
  logic [pse_event_pkg::SYNC_W-1:0] sync_r;

  assign pins = {ext_reset_n_pin, rail_uvlo_pin, rail_uv_pin, core_warn_pin,
                 core_uvlo_pin, temp_below_low_pin, over_temp_pin};

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r <= pse_event_pkg::SYNC_RESET;
      sync_r <= pse_event_pkg::SYNC_RESET;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  logic over_temp;
  logic temp_low;
  logic core_uvlo;
  logic core_warn;
  logic rail_uv;
  logic rail_uvlo;
  logic ext_reset;

  assign over_temp = sync_r[pse_event_pkg::PIN_OVER_TEMP];
  assign temp_low = sync_r[pse_event_pkg::PIN_TEMP_LOW];
  assign core_uvlo = sync_r[pse_event_pkg::PIN_CORE_UVLO];
  assign core_warn = sync_r[pse_event_pkg::PIN_CORE_WARN];
  assign rail_uv = sync_r[pse_event_pkg::PIN_RAIL_UV];
  assign rail_uvlo = sync_r[pse_event_pkg::PIN_RAIL_UVLO];
  assign ext_reset = !sync_r[pse_event_pkg::PIN_EXT_RESET_N];

  // command decode
  logic peek_sl;
  logic clear_sl;
  logic peek_sup;
  logic clear_sup;

  assign peek_sl = cmd_valid &&
    (cmd_code == pse_event_pkg::CMD_START_LIMIT_PEEK);
  assign clear_sl = cmd_valid &&
    (cmd_code == pse_event_pkg::CMD_START_LIMIT_CLEAR);
  assign peek_sup = cmd_valid && (cmd_code == pse_event_pkg::CMD_SUPPLY_PEEK);
  assign clear_sup = cmd_valid && (cmd_code == pse_event_pkg::CMD_SUPPLY_CLEAR);

  // limit timers
  logic [pse_event_pkg::PORTS-1:0] limit_expired;

  limit_fault_timer #(
    .LIMIT_FAULT_CYCLES(LIMIT_FAULT_CYCLES)
  ) u_limit_timer (
    .mclk(mclk),
    .rst(rst),
    .limit_active(limit_active),
    .limit_expired(limit_expired)
  );

  // thermal state: hot from over temperature until below the low threshold
  pse_event_pkg::thermal_t th_r;
  pse_event_pkg::thermal_t th_nxt;

  always_comb begin
    th_nxt = th_r;
    case (th_r)
      pse_event_pkg::TH_NORMAL: begin
        if (over_temp) begin
          th_nxt = pse_event_pkg::TH_HOT;
        end
      end
      pse_event_pkg::TH_HOT: begin
        if (temp_low && !over_temp) begin
          th_nxt = pse_event_pkg::TH_NORMAL;
        end
      end
      default: th_nxt = pse_event_pkg::TH_NORMAL;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      th_r <= pse_event_pkg::TH_NORMAL;
    end else begin
      th_r <= th_nxt;
    end
  end

  // rail undervoltage only drops ports while the mask allows it
  logic rail_shutdown;
  assign rail_shutdown = rail_uv && supply_event_shutdown_mask;

  // port control outputs; the thermal flag itself does not hold ports off
  always_ff @(posedge mclk) begin
    if (rst) begin
      all_ports_off_r <= 1'b0;
      force_off_mode_r <= 1'b0;
    end else begin
      all_ports_off_r <= (th_nxt == pse_event_pkg::TH_HOT) ||
        rail_shutdown;
      force_off_mode_r <= (th_nxt == pse_event_pkg::TH_HOT);
    end
  end

  // per-port side effects of an undervoltage turn-off
  logic [pse_event_pkg::PORTS-1:0] uv_off;
  assign uv_off = rail_shutdown ? port_powered : '0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      uv_port_clear_r <= '0;
      uv_change_set_r <= '0;
      uv_status_update_r <= '0;
    end else begin
      uv_port_clear_r <= uv_off;
      uv_change_set_r <= uv_off;
      uv_status_update_r <= uv_off;
    end
  end

  // lockouts restart the whole device; logic stays up while hot
  always_ff @(posedge mclk) begin
    if (rst) begin
      por_request_r <= 1'b0;
    end else begin
      por_request_r <= rail_uvlo || core_uvlo;
    end
  end

  // start/limit flags: set beats clear, per bit
  logic [7:0] sl_r;
  logic [7:0] sl_set;
  logic [7:0] sl_clr;
  logic [pse_event_pkg::PORTS-1:0] port_off_any;

  assign port_off_any = port_turned_off | uv_off;

  genvar p;
  generate
    for (p = 0; p < pse_event_pkg::PORTS; p++) begin : g_sl
      assign sl_set[pse_event_pkg::LIMIT_LSB+p] = limit_expired[p];
      assign sl_set[pse_event_pkg::TURN_ON_LSB+p] = start_timeout[p] ||
        (class_det_error[p] && std_enable_turn_on[p]);
      assign sl_clr[pse_event_pkg::LIMIT_LSB+p] = port_off_any[p];
      assign sl_clr[pse_event_pkg::TURN_ON_LSB+p] = port_off_any[p];
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      sl_r <= pse_event_pkg::START_LIMIT_RESET;
    end else begin
      // sticky until cleared; a fresh event wins over any clear, the
      // external reset pin included
      sl_r <= sl_set |
        (sl_r & ~sl_clr & {8{!(clear_sl || ext_reset)}});
    end
  end

  // supply flags, upper nibble only; lower nibble is not stored
  logic [3:0] sup_r;
  logic [3:0] sup_set;
  logic [3:0] sup_keep;

  assign sup_set = {over_temp,
                    core_uvlo || rail_uv,
                    core_warn,
                    rail_uv};

  // external reset spares the core lockout and rail flags
  assign sup_keep = ext_reset ? 4'h5 : 4'hF;

  always_ff @(posedge mclk) begin
    if (rst) begin
      sup_r <= pse_event_pkg::SUPPLY_RESET;
    end else if (clear_sup) begin
      sup_r <= sup_set;
    end else begin
      sup_r <= sup_set | (sup_r & sup_keep);
    end
  end

  // read path: data captured before the clear lands
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      rd_valid_r <= peek_sl || clear_sl || peek_sup || clear_sup;
      if (peek_sup || clear_sup) begin
        rd_data_r <= {sup_r, pse_event_pkg::RESERVED_READ};
      end else if (peek_sl || clear_sl) begin
        rd_data_r <= sl_r;
      end else begin
        rd_data_r <= 8'h00;
      end
    end
  end

  // summary: the clearing read drops these, releasing the line
  assign supply_summary = |sup_r;
  assign start_limit_summary = |sl_r;
  assign int_n = !(supply_summary || start_limit_summary);

endmodule

/* File: test/pse_events_chk.sv */
// assertions on the ports of the event flag block
// assumes one clock, mclk, and synchronous active-high rst
`timescale 1ns/100ps
module pse_events_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register reads
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic rd_valid_r,
  input wire logic [7:0] rd_data_r,
  // events and pins
  input wire logic [3:0] port_powered,
  input wire logic over_temp_pin,
  input wire logic core_uvlo_pin,
  input wire logic core_warn_pin,
  input wire logic rail_uv_pin,
  input wire logic rail_uvlo_pin,
  input wire logic supply_event_shutdown_mask,
  // outputs
  input wire logic all_ports_off_r,
  input wire logic force_off_mode_r,
  input wire logic [3:0] uv_port_clear_r,
  input wire logic [3:0] uv_change_set_r,
  input wire logic [3:0] uv_status_update_r,
  input wire logic por_request_r,
  input wire logic supply_summary,
  input wire logic start_limit_summary,
  input wire logic int_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles with every supply pin idle; 7 covers the synchroniser delay
  logic [2:0] quiet_r;
  always_ff @(posedge mclk) begin
    if (rst || over_temp_pin || core_uvlo_pin || core_warn_pin ||
        rail_uv_pin || rail_uvlo_pin)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  sequence clear_then_peek;
    cmd_valid && cmd_code == 8'h0B && quiet_r == 3'h7 ##[1:5]
      cmd_valid && cmd_code == 8'h0A && quiet_r == 3'h7;
  endsequence
  read_answers_a: assert property (
    cmd_valid && cmd_code[7:2] == 6'h02 |=> rd_valid_r)
    else $error("known code got no answer");
  unknown_refused_a: assert property (
    cmd_valid && cmd_code[7:2] != 6'h02 |=> !rd_valid_r && !rd_data_r)
    else $error("unknown code answered");
  reserved_low_a: assert property (
    cmd_valid && cmd_code[7:1] == 7'h05 |=> rd_data_r[3:0] == 4'h0)
    else $error("reserved supply bits not zero");
  clear_empties_a: assert property (
    clear_then_peek |=> rd_data_r[7:4] == 4'h0 && !supply_summary)
    else $error("clearing read left supply flags");
  int_summary_a: assert property (
    int_n == !(supply_summary || start_limit_summary))
    else $error("interrupt line disagrees with summaries");
  boot_lockout_a: assert property (
    $fell(rst) |-> !int_n && supply_summary)
    else $error("core lockout flag not set after reset");
  thermal_off_a: assert property (
    over_temp_pin [*5] |-> all_ports_off_r && force_off_mode_r)
    else $error("hot without ports off");
  rail_masked_a: assert property (
    (rail_uv_pin && supply_event_shutdown_mask) [*5] ##0
      port_powered == 4'hF |-> all_ports_off_r &&
      (uv_port_clear_r & uv_change_set_r & uv_status_update_r) == 4'hF)
    else $error("masked rail undervoltage kept ports on");
  lockout_por_a: assert property (
    (rail_uvlo_pin || core_uvlo_pin) [*5] |-> por_request_r)
    else $error("lockout without reset request");
endmodule
bind pse_start_limit_supply_events pse_events_chk u_pse_events_chk (
  .mclk, .rst, .cmd_valid, .cmd_code, .rd_valid_r, .rd_data_r,
  .port_powered, .over_temp_pin, .core_uvlo_pin, .core_warn_pin,
  .rail_uv_pin, .rail_uvlo_pin, .supply_event_shutdown_mask,
  .all_ports_off_r, .force_off_mode_r, .uv_port_clear_r, .uv_change_set_r,
  .uv_status_update_r, .por_request_r, .supply_summary,
  .start_limit_summary, .int_n);

/* File: test/host_model.sv */
// host issuing one-byte register reads
// assumes mclk from the bench; requests change on the falling edge
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic mclk,
  // command and answer
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  input wire logic rd_valid_r,
  input wire logic [7:0] rd_data_r
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
  end
  // idle code is scrambled so a stale code is never mistaken for a read
  task automatic read(input logic [7:0] c, input int gap,
                      output logic [7:0] d, output logic v);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code = c;
    @(negedge mclk);
    d = rd_data_r;
    v = rd_valid_r;
    cmd_valid = 1'b0;
    cmd_code = ~c;
    repeat (gap) @(negedge mclk);
  endtask
endmodule

/* File: test/pse_start_limit_supply_events_test.sv */
// self-checking bench for the event flag block against a flag model
// assumes host_model for reads; other inputs change at the falling edge
`timescale 1ns/100ps
module pse_start_limit_supply_events_test;
  logic mclk, rst, cmd_valid, rd_valid_r, mask, apo, fom, por, ss, ls, int_n;
  logic [7:0] cmd_code, rd_data_r;
  logic [3:0] lim, sto, cde, std, off, pwr, uvc, uvs, uvu;
  logic [6:0] pv;
  int n_errors = 0, cmp_count = 0, seed = 83186, sup = 4, sl = 0, p, q;
  pse_start_limit_supply_events #(.LIMIT_FAULT_CYCLES(20))
    u_pse_start_limit_supply_events (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .limit_active(lim),
    .start_timeout(sto), .class_det_error(cde), .std_enable_turn_on(std),
    .port_turned_off(off), .port_powered(pwr), .over_temp_pin(pv[0]),
    .temp_below_low_pin(pv[1]), .core_uvlo_pin(pv[2]),
    .core_warn_pin(pv[3]), .rail_uv_pin(pv[4]), .rail_uvlo_pin(pv[5]),
    .ext_reset_n_pin(pv[6]), .supply_event_shutdown_mask(mask),
    .all_ports_off_r(apo), .force_off_mode_r(fom), .uv_port_clear_r(uvc),
    .uv_change_set_r(uvs), .uv_status_update_r(uvu),
    .por_request_r(por), .supply_summary(ss), .start_limit_summary(ls),
    .int_n(int_n));
  host_model u_host_model (.mclk(mclk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r));
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // supply conditions still present; a clear cannot remove these
  function automatic int hold();
    return {pv[0], pv[2] | pv[4], pv[3], pv[4]};
  endfunction
  task automatic pn(input logic [6:0] v, input int n);
    @(negedge mclk);
    pv = v;
    repeat (n) @(negedge mclk);
    sup |= hold();
    if (!pv[6]) begin
      sup &= 5;
      sl = 0;
    end
  endtask
  task automatic rd(input logic [7:0] c);
    logic [7:0] d, e;
    logic v;
    u_host_model.read(c, $random(seed) & 3, d, v);
    e = c[7:1] == 7'h05 ? 8'(sup << 4) : c[7:1] == 7'h04 ? 8'(sl) : 8'h00;
    chk("read data", d, e);
    chk("read valid", {7'h0, v}, {7'h0, c[7:2] == 6'h02});
    if (c == 8'h0B) sup = hold();
    if (c == 8'h09) sl = 0;
    chk("int_n", {7'h0, int_n}, {7'h0, sup == 0 && sl == 0});
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    mask = 1'b0;
    pv = 7'h40;
    {lim, sto, cde, std, off} = '0;
    pwr = 4'hF;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    pn(7'h40, 8);
    rd(8'h0A);
    rd(8'h0B);
    rd(8'h0A);
    pn(7'h41, 6);
    chk("ports off", {6'h0, apo, fom}, 8'h03);
    pn(7'h42, 6);
    chk("ports off", {6'h0, apo, fom}, 8'h00);
    pn(7'h48, 4);
    pn(7'h40, 4);
    rd(8'h0A);
    pn(7'h44, 6);
    chk("por", {7'h0, por}, 8'h01);
    pn(7'h40, 4);
    rd(8'h0B);
    pn(7'h50, 8);
    chk("uv off", {apo, uvc}, 8'h00);
    rd(8'h0B);
    rd(8'h0A);
    mask = 1'b1;
    repeat (5) @(negedge mclk);
    chk("uv change", {uvc, uvs}, 8'hFF);
    chk("uv update", {3'h0, apo, uvu}, 8'h1F);
    mask = 1'b0;
    pn(7'h48, 4);
    sto = 4'h2;
    pn(7'h00, 4);
    sto = 4'h0;
    pn(7'h40, 4);
    rd(8'h0A);
    rd(8'h08);
    for (int i = 0; i < 6; i++) begin
      p = $random(seed) & 3;
      q = $random(seed) & 3;
      @(negedge mclk);
      sto = 4'h1 << p;
      std = 4'($random(seed));
      @(negedge mclk);
      sto = 4'h0;
      cde = 4'h1 << q;
      @(negedge mclk);
      cde = 4'h0;
      sl |= (1 << p) | ((1 << q) & std);
      rd(i[0] ? 8'h09 : 8'h08);
      rd(8'(($random(seed) & 8'hEF) | 8'h10));
    end
    lim = 4'h3;
    repeat (10) @(negedge mclk);
    lim = 4'h1;
    repeat (14) @(negedge mclk);
    lim = 4'h0;
    sl |= 8'h10;
    rd(8'h08);
    off = 4'h1;
    @(negedge mclk);
    off = 4'h0;
    sl &= 8'hEE;
    rd(8'h08);
    rd(8'h07);
    rd(8'h0C);
    pn(7'h60, 6);
    chk("por", {7'h0, por}, 8'h01);
    complete_run();
  end
endmodule
